// file: pbc_pkg.sv
// constants for the port B/C pin function select block
package pbc_pkg;

  // register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFS_PB_FSEL = 8'h00;
  localparam logic [7:0] OFS_PC_DIR = 8'h04;
  localparam logic [7:0] OFS_PC_FSEL_HI = 8'h08;
  localparam logic [7:0] OFS_PC_FSEL_LO = 8'h0C;
  localparam logic [7:0] OFS_PC_DATA = 8'h10;
  localparam logic [7:0] OFS_PC_PINS = 8'h14;
  localparam logic [7:0] OFS_PB_PINS = 8'h18;

  // reset values
  localparam logic [15:0] RST_PB_FSEL = 16'h80C0;
  localparam logic [15:0] RST_PC_DIR = 16'h8000;
  localparam logic [15:0] RST_PC_FSEL_HI = 16'hC000;
  localparam logic [15:0] RST_PC_FSEL_LO = 16'h0BFF;
  localparam logic [15:0] RST_PC_DATA = 16'h0000;

  // bits that always read as one
  localparam logic [15:0] ONE_PB_FSEL = 16'h80C0;
  localparam logic [15:0] ONE_PC_DIR = 16'h8000;
  localparam logic [15:0] ONE_PC_FSEL_HI = 16'hC000;
  localparam logic [15:0] ONE_PC_FSEL_LO = 16'h0AAA;

  // pin counts and field positions
  localparam int PB_PINS = 8;
  localparam int PC_PINS = 15;
  localparam int PC_HI_LSB = 8;
  localparam int PC_HI_PINS = 7;
  localparam int PB_ADDR17_BIT = 9;
  localparam int PB_ADDR16_BIT = 8;
  localparam int PB_TIMER_EXT_CLOCK_B_BIT = 5;
  localparam int PB_TIMER_EXT_CLOCK_A_BIT = 4;
  localparam int PB_PWM_LSB = 0;
  localparam int PB_PWM_PINS = 4;
  localparam int PC_DACK1_PIN = 12;
  localparam int PC_DACK0_PIN = 11;

  // two-bit mode codes of port C pins
  localparam logic [1:0] MD_GPIO = 2'h0;
  localparam logic [1:0] MD_ONESHOT = 2'h1;
  localparam logic [1:0] MD_DMAACK = 2'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    PBC_EXP_ROM_OFF,
    PBC_EXP_ROM_ON,
    PBC_SINGLE_CHIP
  } pbc_chip_mode_t;

endpackage

// file: pbc_axil_slave.sv
// AXI4-Lite slave front end for the pin function select registers
`timescale 1ns/1ps
module pbc_axil_slave #(
  parameter int AW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [AW-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_hit,
  output logic [AW-1:0] rd_addr,
  input wire logic rd_hit,
  input wire logic [31:0] rd_data
);

  logic aw_held_r;
  logic w_held_r;
  logic aw_take;
  logic w_take;
  logic ar_take;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  // address and data may arrive in either order
  assign wr_en = aw_held_r & w_held_r;
  assign rd_addr = s_axi_araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      wr_addr <= '0;
      s_axi_awready <= 1'b0;
    end else if (aw_take) begin
      aw_held_r <= 1'b1;
      wr_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_en) begin
      aw_held_r <= 1'b0;
    end else if (!aw_held_r && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
      s_axi_wready <= 1'b0;
    end else if (w_take) begin
      w_held_r <= 1'b1;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_en) begin
      w_held_r <= 1'b0;
    end else if (!w_held_r && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pbc_pkg::RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? pbc_pkg::RESP_OKAY : pbc_pkg::RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // one read in flight; data captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= pbc_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_hit ? rd_data : 32'h0000_0000;
      s_axi_rresp <= rd_hit ? pbc_pkg::RESP_OKAY : pbc_pkg::RESP_DECERR;
      s_axi_arready <= 1'b0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule // pbc_axil_slave

// file: pbc_pin_mux.sv
// port B low and port C pin function multiplexer with its registers
// Summary of operation
// - B pins 7,6: bit 0 gives address only ROM-off; 1 adds ROM-on, not single
// - reserved control bits read back as one; software writes only one
// - B pins 5,4: 0 general I/O, 1 timer clock input B and A
// - B pins 3..0: 0 general I/O, 1 drive PWM outputs nine to six
// - C direction bit 1 makes a general I/O pin output, 0 input
// - C direction ignored for pins in a peripheral function
// - C direction resets to 8000 hex and holds through standby and sleep
// - C function registers reset to C000 and 0BFF hex, otherwise held
// - high C function register serves pins 14..8, low one pins 7..0 (here the low one is storage only; pins 7..0 stay general I/O)
// - C pins 14,13,10,9,8: 00 general I/O, 01 one-shot, rest reserved
// - C pin 12: 01 one-shot, 10 DMA channel 1 acknowledge, 11 reserved
// - C pin 11: 01 one-shot, 10 DMA channel 0 acknowledge, 11 reserved
// - C direction bit 15 is read only and reads one
// - B function register resets to 80C0 hex, otherwise held
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module pbc_pin_mux #(
  parameter int AW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pbc_pkg::pbc_chip_mode_t chip_mode,
  input wire logic [7:0] pb_gpio_out,
  input wire logic [7:0] pb_gpio_oe,
  input wire logic addr_line_17,
  input wire logic addr_line_16,
  input wire logic [3:0] pwm_out,
  input wire logic [6:0] oneshot_out,
  input wire logic dma_req0_ack_out,
  input wire logic dma_req1_ack_out,
  input wire logic [7:0] pb_pin_in,
  input wire logic [14:0] pc_pin_in,
  output logic [7:0] pb_pin_out,
  output logic [7:0] pb_pin_oe,
  output logic [14:0] pc_pin_out,
  output logic [14:0] pc_pin_oe,
  output logic [7:0] pb_pin_val,
  output logic timer_ext_clock_a,
  output logic timer_ext_clock_b
);

  logic [15:0] pb_fsel_r;
  logic [15:0] pc_dir_r;
  logic [15:0] pc_fsel_hi_r;
  logic [15:0] pc_fsel_lo_r;
  logic [15:0] pc_data_r;
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic [AW-1:0] rd_addr;
  logic rd_hit;
  logic [31:0] rd_data;
  logic [7:0] pb_s1_r;
  logic [7:0] pb_s2_r;
  logic [7:0] pb_s3_r;
  logic [14:0] pc_s1_r;
  logic [14:0] pc_s2_r;
  logic [14:0] pc_s3_r;
  logic [14:0] pc_val_r;
  logic [7:0] pb_out_nxt;
  logic [7:0] pb_oe_nxt;
  logic [14:0] pc_out_nxt;
  logic [14:0] pc_oe_nxt;
  logic addr17_sel;
  logic addr16_sel;

  pbc_axil_slave #(
    .AW(AW)
  ) u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_hit(wr_hit),
    .rd_addr(rd_addr),
    .rd_hit(rd_hit),
    .rd_data(rd_data)
  );

  // low two byte lanes carry the 16-bit registers
  function automatic logic [15:0] merge(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  function automatic logic is_reg(input logic [AW-1:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    return (w == pbc_pkg::OFS_PB_FSEL) || (w == pbc_pkg::OFS_PC_DIR) ||
      (w == pbc_pkg::OFS_PC_FSEL_HI) || (w == pbc_pkg::OFS_PC_FSEL_LO) ||
      (w == pbc_pkg::OFS_PC_DATA) || (w == pbc_pkg::OFS_PC_PINS) ||
      (w == pbc_pkg::OFS_PB_PINS);
  endfunction

  logic [7:0] wr_word;
  logic [7:0] rd_word;
  assign wr_word = {wr_addr[7:2], 2'b00};
  assign rd_word = {rd_addr[7:2], 2'b00};
  assign wr_hit = is_reg(wr_addr);
  assign rd_hit = is_reg(rd_addr);

  // reset covers power-on and hardware standby only; standby and sleep
  // do not reach this block, so every register simply holds
  // port B function
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pb_fsel_r <= pbc_pkg::RST_PB_FSEL;
    end else if (wr_en && wr_word == pbc_pkg::OFS_PB_FSEL) begin
      pb_fsel_r <= merge(pb_fsel_r, wr_data, wr_strb) | pbc_pkg::ONE_PB_FSEL;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_dir_r <= pbc_pkg::RST_PC_DIR;
    end else if (wr_en && wr_word == pbc_pkg::OFS_PC_DIR) begin
      pc_dir_r <= merge(pc_dir_r, wr_data, wr_strb) | pbc_pkg::ONE_PC_DIR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_fsel_hi_r <= pbc_pkg::RST_PC_FSEL_HI;
    end else if (wr_en && wr_word == pbc_pkg::OFS_PC_FSEL_HI) begin
      pc_fsel_hi_r <= merge(pc_fsel_hi_r, wr_data, wr_strb) |
        pbc_pkg::ONE_PC_FSEL_HI;
    end
  end

  // low-pin map kept as storage only; those pins stay general I/O here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_fsel_lo_r <= pbc_pkg::RST_PC_FSEL_LO;
    end else if (wr_en && wr_word == pbc_pkg::OFS_PC_FSEL_LO) begin
      pc_fsel_lo_r <= merge(pc_fsel_lo_r, wr_data, wr_strb) |
        pbc_pkg::ONE_PC_FSEL_LO;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_data_r <= pbc_pkg::RST_PC_DATA;
    end else if (wr_en && wr_word == pbc_pkg::OFS_PC_DATA) begin
      pc_data_r <= merge(pc_data_r, wr_data, wr_strb);
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (rd_word)
      pbc_pkg::OFS_PB_FSEL: rd_data[15:0] = pb_fsel_r;
      pbc_pkg::OFS_PC_DIR: rd_data[15:0] = pc_dir_r;
      pbc_pkg::OFS_PC_FSEL_HI: rd_data[15:0] = pc_fsel_hi_r;
      pbc_pkg::OFS_PC_FSEL_LO: rd_data[15:0] = pc_fsel_lo_r;
      pbc_pkg::OFS_PC_DATA: rd_data[15:0] = pc_data_r;
      pbc_pkg::OFS_PC_PINS: rd_data[14:0] = pc_val_r;
      pbc_pkg::OFS_PB_PINS: rd_data[7:0] = pb_pin_val;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // pins are asynchronous: three stages, accept once stages two and three
  // agree, so a single-cycle glitch never reaches the timer clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pb_s1_r <= '0;
      pb_s2_r <= '0;
      pb_s3_r <= '0;
      pb_pin_val <= '0;
    end else begin
      pb_s1_r <= pb_pin_in;
      pb_s2_r <= pb_s1_r;
      pb_s3_r <= pb_s2_r;
      pb_pin_val <= (pb_pin_val & (pb_s2_r ^ pb_s3_r)) |
        (pb_s3_r & ~(pb_s2_r ^ pb_s3_r));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_s1_r <= '0;
      pc_s2_r <= '0;
      pc_s3_r <= '0;
      pc_val_r <= '0;
    end else begin
      pc_s1_r <= pc_pin_in;
      pc_s2_r <= pc_s1_r;
      pc_s3_r <= pc_s2_r;
      pc_val_r <= (pc_val_r & (pc_s2_r ^ pc_s3_r)) |
        (pc_s3_r & ~(pc_s2_r ^ pc_s3_r));
    end
  end

  assign addr17_sel = (chip_mode == pbc_pkg::PBC_EXP_ROM_OFF) ||
    (chip_mode == pbc_pkg::PBC_EXP_ROM_ON &&
     pb_fsel_r[pbc_pkg::PB_ADDR17_BIT]);
  assign addr16_sel = (chip_mode == pbc_pkg::PBC_EXP_ROM_OFF) ||
    (chip_mode == pbc_pkg::PBC_EXP_ROM_ON &&
     pb_fsel_r[pbc_pkg::PB_ADDR16_BIT]);

  always_comb begin
    pb_out_nxt = pb_gpio_out;
    pb_oe_nxt = pb_gpio_oe;
    if (addr17_sel) begin
      pb_out_nxt[7] = addr_line_17;
      pb_oe_nxt[7] = 1'b1;
    end
    if (addr16_sel) begin
      pb_out_nxt[6] = addr_line_16;
      pb_oe_nxt[6] = 1'b1;
    end
    if (pb_fsel_r[pbc_pkg::PB_TIMER_EXT_CLOCK_B_BIT]) begin
      pb_oe_nxt[5] = 1'b0;
    end
    if (pb_fsel_r[pbc_pkg::PB_TIMER_EXT_CLOCK_A_BIT]) begin
      pb_oe_nxt[4] = 1'b0;
    end
    for (int k = 0; k < pbc_pkg::PB_PWM_PINS; k++) begin
      if (pb_fsel_r[pbc_pkg::PB_PWM_LSB + k]) begin
        pb_out_nxt[k] = pwm_out[k];
        pb_oe_nxt[k] = 1'b1;
      end
    end
  end

  for (genvar i = 0; i < pbc_pkg::PC_PINS; i++) begin : g_pc
    logic per_sel;
    logic per_val;
    if (i >= pbc_pkg::PC_HI_LSB) begin : g_hi
      localparam int F = 2 * (i - pbc_pkg::PC_HI_LSB);
      localparam bit HAS_ACK = (i == pbc_pkg::PC_DACK0_PIN) ||
        (i == pbc_pkg::PC_DACK1_PIN);
      logic [1:0] code;
      logic ack;
      assign code = pc_fsel_hi_r[F +: 2];
      assign ack = (i == pbc_pkg::PC_DACK1_PIN) ? dma_req1_ack_out :
        dma_req0_ack_out;
      assign per_sel = (code == pbc_pkg::MD_ONESHOT) ||
        (HAS_ACK && code == pbc_pkg::MD_DMAACK);
      assign per_val = (code == pbc_pkg::MD_ONESHOT) ?
        oneshot_out[i - pbc_pkg::PC_HI_LSB] : ack;
    end else begin : g_lo
      assign per_sel = 1'b0;
      assign per_val = 1'b0;
    end
    assign pc_oe_nxt[i] = per_sel | pc_dir_r[i];
    assign pc_out_nxt[i] = per_sel ? per_val : pc_data_r[i];
  end

  // registered pads: one cycle from any select change to the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pb_pin_out <= '0;
      pb_pin_oe <= '0;
      pc_pin_out <= '0;
      pc_pin_oe <= '0;
    end else begin
      pb_pin_out <= pb_out_nxt;
      pb_pin_oe <= pb_oe_nxt;
      pc_pin_out <= pc_out_nxt;
      pc_pin_oe <= pc_oe_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_ext_clock_a <= 1'b0;
      timer_ext_clock_b <= 1'b0;
    end else begin
      timer_ext_clock_a <= pb_pin_val[4] & pb_fsel_r[pbc_pkg::PB_TIMER_EXT_CLOCK_A_BIT];
      timer_ext_clock_b <= pb_pin_val[5] & pb_fsel_r[pbc_pkg::PB_TIMER_EXT_CLOCK_B_BIT];
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  addr_route_a: assert property (
    addr17_sel |=> pb_pin_oe[7] && pb_pin_out[7] == $past(addr_line_17))
    else $error("address line 17 not routed");

  single_chip_a: assert property (
    chip_mode == pbc_pkg::PBC_SINGLE_CHIP
    |=> pb_pin_out[7:6] == $past(pb_gpio_out[7:6]) &&
        pb_pin_oe[7:6] == $past(pb_gpio_oe[7:6]))
    else $error("single chip pins not general I/O");

  reserved_ones_a: assert property (
    wr_en |=> pb_fsel_r[7:6] == 2'b11 && pb_fsel_r[15] &&
      pc_fsel_hi_r[15:14] == 2'b11)
    else $error("reserved bits lost their ones");

  timer_clock_a: assert property (
    pb_fsel_r[pbc_pkg::PB_TIMER_EXT_CLOCK_A_BIT]
    |=> !pb_pin_oe[4] && timer_ext_clock_a == $past(pb_pin_val[4]))
    else $error("timer clock A not taken from pin");

  pwm_drive_a: assert property (
    pb_fsel_r[pbc_pkg::PB_PWM_LSB + 3]
    |=> pb_pin_oe[3] && pb_pin_out[3] == $past(pwm_out[3]))
    else $error("PWM nine not on its pin");

  dir_follow_a: assert property (
    ##1 pc_pin_oe[0] == $past(pc_dir_r[0]))
    else $error("direction bit not applied");

  dir_ignored_a: assert property (
    pc_fsel_hi_r[13:12] == pbc_pkg::MD_ONESHOT
    |=> pc_pin_oe[14] && pc_pin_out[14] == $past(oneshot_out[6]))
    else $error("one-shot pin follows direction");

  reset_value_a: assert property (
    @(posedge aclk) disable iff (1'b0)
    !aresetn |=> pc_dir_r == pbc_pkg::RST_PC_DIR &&
      pc_fsel_hi_r == pbc_pkg::RST_PC_FSEL_HI &&
      pc_fsel_lo_r == pbc_pkg::RST_PC_FSEL_LO &&
      pb_fsel_r == pbc_pkg::RST_PB_FSEL)
    else $error("register reset value wrong");

  fsel_hold_a: assert property (
    !wr_en |=> $stable(pc_fsel_hi_r) && $stable(pc_fsel_lo_r))
    else $error("function register changed unwritten");

  split_regs_a: assert property (
    wr_en && wr_word == pbc_pkg::OFS_PC_FSEL_HI |=> $stable(pc_fsel_lo_r))
    else $error("high write touched low register");

  reserved_code_a: assert property (
    pc_fsel_hi_r[13:12] == 2'h3
    |=> pc_pin_oe[14] == $past(pc_dir_r[14]) &&
        pc_pin_out[14] == $past(pc_data_r[14]))
    else $error("reserved code drove a peripheral");

  dack_one_a: assert property (
    pc_fsel_hi_r[9:8] == pbc_pkg::MD_DMAACK
    |=> pc_pin_oe[12] && pc_pin_out[12] == $past(dma_req1_ack_out))
    else $error("DMA acknowledge 1 not on pin 12");

  dack_zero_a: assert property (
    pc_fsel_hi_r[7:6] == pbc_pkg::MD_DMAACK
    |=> pc_pin_oe[11] && pc_pin_out[11] == $past(dma_req0_ack_out))
    else $error("DMA acknowledge 0 not on pin 11");

  dir_top_a: assert property (
    wr_en && wr_word == pbc_pkg::OFS_PC_DIR |=> pc_dir_r[15])
    else $error("direction bit 15 cleared");

  pb_hold_a: assert property (
    !wr_en |=> $stable(pb_fsel_r))
    else $error("port B function changed unwritten");

endmodule // pbc_pin_mux

// file: pbc_pin_mux_bench.sv
// self-checking bench for the port B/C pin function multiplexer
`timescale 1ns/1ps
module pbc_pin_mux_bench;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  pbc_pkg::pbc_chip_mode_t chip_mode = pbc_pkg::PBC_EXP_ROM_OFF;
  logic [7:0] pb_gpio_out = 8'h00, pb_gpio_oe = 8'h00, pb_pin_in = 8'h00;
  logic addr_line_17 = 1'h0, addr_line_16 = 1'h0;
  logic dma_req0_ack_out = 1'h0, dma_req1_ack_out = 1'h0;
  logic [3:0] pwm_out = 4'h0;
  logic [6:0] oneshot_out = 7'h00;
  logic [14:0] pc_pin_in = 15'h0000;
  logic [7:0] pb_pin_out, pb_pin_oe, pb_pin_val;
  logic [14:0] pc_pin_out, pc_pin_oe;
  logic timer_ext_clock_a, timer_ext_clock_b;
  logic [15:0] m_pbf, m_dir, m_hi, m_lo, m_dat;
  logic [7:0] e_bout, e_boe;
  logic [14:0] e_cout, e_coe;
  logic [31:0] rv, rd, q;
  logic [1:0] r;
  integer seed = 32'h677c;
  integer n_errors = 0, checks = 0, cyc = 0, i;

  pbc_pin_mux i_pbc_pin_mux (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chip_mode, .pb_gpio_out,
    .pb_gpio_oe, .addr_line_17, .addr_line_16, .pwm_out, .oneshot_out,
    .dma_req0_ack_out, .dma_req1_ack_out, .pb_pin_in, .pc_pin_in,
    .pb_pin_out, .pb_pin_oe, .pc_pin_out, .pc_pin_oe, .pb_pin_val,
    .timer_ext_clock_a, .timer_ext_clock_b
  );

  initial begin
    forever #12.5 aclk = ~aclk;
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // a hung handshake ends here; the tests need about a thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      close_out;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [15:0] mrg(input logic [15:0] old,
      input logic [31:0] d, input logic [3:0] s, input logic [15:0] ones);
    logic [15:0] m;
    m = {{8{s[1]}}, {8{s[0]}}};
    return (old & ~m) | (d[15:0] & m) | ones;
  endfunction

  function automatic logic [31:0] rd_exp(input logic [7:0] a);
    case (a)
      8'h00: return {16'h0, m_pbf};
      8'h04: return {16'h0, m_dir};
      8'h08: return {16'h0, m_hi};
      8'h0C: return {16'h0, m_lo};
      8'h10: return {16'h0, m_dat};
      8'h14: return {17'h0, pc_pin_in};
      8'h18: return {24'h0, pb_pin_in};
      default: return 32'h0;
    endcase
  endfunction

  // master holds each channel until its own handshake edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [1:0] rsp);
    logic done;
    done = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        done = 1'h1;
      end
    end
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] rsp);
    logic done;
    done = 1'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) begin
        d = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        done = 1'h1;
      end
    end
  endtask

  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    m_pbf = 16'h80C0;
    m_dir = 16'h8000;
    m_hi = 16'hC000;
    m_lo = 16'h0BFF;
    m_dat = 16'h0000;
    for (int k = 0; k < 5; k++) begin
      axr(8'(k * 4), q, r);
      chk("reset value", q, rd_exp(8'(k * 4)));
      chk("rresp", {30'h0, r}, 32'h0);
    end
    $display("test reset values done");
  endtask

  task automatic exp_pins;
    logic [1:0] md;
    logic sel;
    e_bout = pb_gpio_out;
    e_boe = pb_gpio_oe;
    for (int k = 0; k < 4; k++) begin
      if (m_pbf[k]) {e_bout[k], e_boe[k]} = {pwm_out[k], 1'h1};
    end
    for (int k = 4; k < 6; k++) begin
      if (m_pbf[k]) e_boe[k] = 1'h0;
    end
    for (int k = 6; k < 8; k++) begin
      sel = (chip_mode == pbc_pkg::PBC_EXP_ROM_OFF) ||
            (chip_mode == pbc_pkg::PBC_EXP_ROM_ON && m_pbf[k + 2]);
      if (sel) begin
        e_bout[k] = (k == 7) ? addr_line_17 : addr_line_16;
        e_boe[k] = 1'h1;
      end
    end
    e_cout = m_dat[14:0];
    e_coe = m_dir[14:0];
    for (int k = 8; k < 15; k++) begin
      md = m_hi[2 * (k - 8) +: 2];
      if (md == 2'h1) {e_cout[k], e_coe[k]} = {oneshot_out[k - 8], 1'h1};
      if (md == 2'h2 && k == 12) {e_cout[k], e_coe[k]} = {dma_req1_ack_out, 1'h1};
      if (md == 2'h2 && k == 11) {e_cout[k], e_coe[k]} = {dma_req0_ack_out, 1'h1};
    end
  endtask

  task automatic step(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    logic [1:0] rsp;
    axw(a, d, s, rsp);
    chk("bresp", {30'h0, rsp}, (a > 8'h18) ? 32'h3 : 32'h0);
    case (a)
      8'h00: m_pbf = mrg(m_pbf, d, s, 16'h80C0);
      8'h04: m_dir = mrg(m_dir, d, s, 16'h8000);
      8'h08: m_hi = mrg(m_hi, d, s, 16'hC000);
      8'h0C: m_lo = mrg(m_lo, d, s, 16'h0AAA);
      8'h10: m_dat = mrg(m_dat, d, s, 16'h0000);
      default: ;
    endcase
    repeat (6) @(posedge aclk);
    exp_pins;
    chk("pb_pin_oe", pb_pin_oe, e_boe);
    chk("pb_pin_out", pb_pin_out & e_boe, e_bout & e_boe);
    chk("pc_pin_oe", pc_pin_oe, e_coe);
    chk("pc_pin_out", pc_pin_out & e_coe, e_cout & e_coe);
    chk("clock a", timer_ext_clock_a, pb_pin_in[4] & m_pbf[4]);
    chk("clock b", timer_ext_clock_b, pb_pin_in[5] & m_pbf[5]);
    chk("pb_pin_val", pb_pin_val, pb_pin_in);
    axr(a, q, rsp);
    chk("read back", q, rd_exp(a));
    chk("rresp", {30'h0, rsp}, (a > 8'h18) ? 32'h3 : 32'h0);
  endtask

  initial begin
    do_reset;
    step(8'h00, 32'h0, 4'h3);
    step(8'h04, 32'h0, 4'h3);
    step(8'h08, 32'h1555, 4'h3);
    step(8'h08, 32'h0280, 4'h3);
    // reserved codes must leave the pins as general I/O
    step(8'h08, 32'h3FFF, 4'hF);
    step(8'h00, 32'hFFFF, 4'h1);
    step(8'h1C, 32'hFFFF, 4'h3);
    step(8'h14, 32'h7FFF, 4'h3);
    $display("test corner writes done");
    for (i = 0; i < 60; i++) begin
      @(posedge aclk);
      rv = $random(seed);
      pb_pin_in <= rv[7:0];
      pc_pin_in <= rv[22:8];
      pwm_out <= rv[26:23];
      addr_line_17 <= rv[27];
      addr_line_16 <= rv[28];
      dma_req0_ack_out <= rv[29];
      dma_req1_ack_out <= rv[30];
      rv = $random(seed);
      pb_gpio_out <= rv[7:0];
      // software keeps timer clock pins as inputs while they are selected
      pb_gpio_oe <= rv[15:8] & ~{2'h0, m_pbf[5:4], 4'h0};
      oneshot_out <= rv[22:16];
      chip_mode <= pbc_pkg::pbc_chip_mode_t'(i[1:0]);
      rv = $random(seed);
      rd = $random(seed);
      step({3'h0, rv[2:0], 2'h0}, rd, rv[6:3]);
    end
    $display("test random traffic done");
    step(8'h04, 32'h7FFF, 4'h3);
    do_reset;
    close_out;
  end
endmodule // pbc_pin_mux_bench
